// File: logic/hbs_pkg.sv
// shared constants and types for the host bus snoop and cycle control block
package hbs_pkg;
    localparam int HBS_DATA_W     = 64;
    localparam int HBS_ADDR_HI    = 31;
    localparam int HBS_ADDR_LO    = 3;
    localparam int HBS_ADDR_W     = HBS_ADDR_HI - HBS_ADDR_LO + 1;
    // management memory window base, byte address, and its 128 KiB extent
    localparam logic [31:0] HBS_SMM_BASE  = 32'h000A_0000;
    localparam logic [31:0] HBS_SMM_LIMIT = 32'h000B_FFFF;
    // memory-or-io code sampled with the strobe: high means memory
    localparam logic        HBS_MIO_MEM   = 1'b1;
    localparam logic        HBS_RST_HIGH  = 1'b0;

    typedef enum logic [2:0] {
        HBS_IDLE,
        HBS_HOLD,
        HBS_SNOOP,
        HBS_HITWAIT,
        HBS_PCI_RUN
    } hbs_state_e;
endpackage : hbs_pkg

// File: logic/hbs_ken_gen.sv
// cache-enable / invalidate line generator for cpu cycles and snoops
`timescale 1ns/100ps
`default_nettype none
module hbs_ken_gen
    import hbs_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    input  wire logic cpu_cycle_start_in,
    input  wire logic cpu_cacheable_in,
    input  wire logic cpu_read_in,
    input  wire logic cpu_first_ready_in,
    input  wire logic cpu_next_addr_in,
    input  wire logic snoop_strobe_in,
    input  wire logic snoop_write_in,
    output logic      cache_enable_invalidate_out
);
    logic ken_q;
    logic cacheable_q;
    logic read_q;
    logic first_done_q;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cacheable_q  <= 1'b0;
            read_q       <= 1'b0;
            first_done_q <= 1'b0;
        end else if (cpu_cycle_start_in) begin
            cacheable_q  <= cpu_cacheable_in;
            read_q       <= cpu_read_in;
            first_done_q <= 1'b0;
        end else if (cpu_first_ready_in || cpu_next_addr_in) begin
            first_done_q <= 1'b1;
        end
    end

    // the line is a level: low means cache-enable, high means do not cache
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ken_q <= 1'b0;
        end else if (snoop_strobe_in) begin
            ken_q <= snoop_write_in; // [R12] [R13]
        end else if (!first_done_q && (cpu_first_ready_in || cpu_next_addr_in)) begin
            // cacheable cycles stay low at the first ready or next-address
            ken_q <= read_q && !cacheable_q; // [R10] [R11]
        end else begin
            ken_q <= 1'b0; // [R11]
        end
    end

    assign cache_enable_invalidate_out = ken_q;
endmodule : hbs_ken_gen // hbs_ken_gen
`default_nettype wire

// File: logic/hbs_bus_ctl.sv
// host bus arbitration, snoop and cycle control for pci access to memory
// Overview of operation
// [R1] address hold raised while a pci initiator targets memory, whole burst
// [R2] address hold dropped after pci memory cycle ends and during peer transfers
// [R3] address hold kept raised while southbridge hold grant is asserted
// [R4] snoop address strobe pulsed for each pci master memory reference
// [R5] back-off asserted when an in-progress cpu cycle must be aborted
// [R6] processor flags dirty hit for the last snooped address
// [R7] processor gives memory-io, data-control, write-read with its strobe
// [R8] locked cpu sequence blocks pci memory access until lock released
// [R9] processor marks burst line fill or writeback with cacheable input
// [R10] cacheable cycle: cache-enable with first ready, or earlier next-address
// [R11] cache-enable line low in cpu cycles, high for uncacheable read
// [R12] during snoop strobe line is high for writes, low for reads
// [R13] snoop invalidate drive ignores the l1 cache enable bit
// [R14] management memory reachable only with management mode sampled on strobe; code also allows it whenever SMM_LOCKED_IN is low
// [R15] host data path is 64 bits, bidirectional
// [R16] processor asserts address strobe in first clock of each cycle
// [R17] bus ready marks read data valid or write data taken
// [R18] next address tells processor a pipelined cycle may start
// [R19] device drives host address only during pci inquire cycles
// [R20] snoop strobe only while address hold already asserted
`timescale 1ns/100ps
`default_nettype none
module hbs_bus_ctl
    import hbs_pkg::*;
(
    input  wire logic                  SYS_CLK_IN,
    input  wire logic                  ARST_N_IN,
    // processor side
    input  wire logic                  CPU_ADDR_STROBE_N_IN,
    input  wire logic [HBS_ADDR_W-1:0] HOST_ADDR_IN,
    output logic      [HBS_ADDR_W-1:0] HOST_ADDR_OUT,
    output logic                       HOST_ADDR_OE_OUT,
    input  wire logic                  MEM_IO_IN,
    input  wire logic                  DATA_CTRL_IN,
    input  wire logic                  WRITE_READ_IN,
    input  wire logic                  CACHE_CYCLE_N_IN,
    input  wire logic                  ATOMIC_LOCK_N_IN,
    input  wire logic                  MGMT_MODE_ACTIVE_N_IN,
    input  wire logic                  SNOOP_DIRTY_HIT_N_IN,
    input  wire logic [HBS_DATA_W-1:0] HOST_DATA_BUS_IN,
    output logic      [HBS_DATA_W-1:0] HOST_DATA_BUS_OUT,
    output logic                       HOST_DATA_BUS_OE_OUT,
    output logic                       ADDR_HOLD_OUT,
    output logic                       SNOOP_ADDR_STROBE_N_OUT,
    output logic                       CYCLE_BACKOFF_N_OUT,
    output logic                       CACHE_ENABLE_INVALIDATE_OUT,
    output logic                       BUS_READY_N_OUT,
    output logic                       NEXT_ADDR_N_OUT,
    // cpu memory side: completion from the memory controller
    input  wire logic                  MEM_CPU_READY_IN,
    input  wire logic                  MEM_CPU_NEXT_IN,
    input  wire logic                  MEM_CPU_ABORT_IN,
    input  wire logic [HBS_DATA_W-1:0] MEM_RD_DATA_IN,
    output logic      [HBS_DATA_W-1:0] MEM_WR_DATA_OUT,
    output logic                       MEM_WR_VALID_OUT,
    // pci target side
    input  wire logic                  PCI_MEM_REQ_IN,
    input  wire logic                  PCI_MEM_WRITE_IN,
    input  wire logic [HBS_ADDR_W-1:0] PCI_MEM_ADDR_IN,
    input  wire logic                  PCI_BURST_DONE_IN,
    input  wire logic                  PCI_PEER_XFER_IN,
    output logic                       PCI_MEM_GRANT_OUT,
    output logic                       PCI_SNOOP_DIRTY_OUT,
    input  wire logic                  SOUTHBRIDGE_HOLD_GRANT_N_IN,
    // configuration
    input  wire logic                  L1_CACHE_ENABLE_BIT_IN,
    input  wire logic                  SMM_LOCKED_IN,
    output logic                       SMM_ACCESS_OK_OUT,
    output logic                       CPU_CYCLE_LOCKED_OUT
);
    hbs_state_e st_q;
    logic       lock_q;
    logic       cpu_busy_q;
    logic       cpu_read_q;
    logic       smm_ok_q;
    logic       dirty_q;
    logic       cycle_backoff_n_q;
    logic       snoop_addr_strobe_n_q;
    logic       rdy_q;
    logic       na_q;
    logic [HBS_ADDR_W-1:0] snoop_addr_q;
    logic [HBS_DATA_W-1:0] rd_data_q;
    logic [HBS_DATA_W-1:0] wr_data_q;
    logic                  wr_valid_q;
    logic       strobe;
    logic       grant_hold;
    logic       l1_unused;

    function automatic logic in_smm(input logic [HBS_ADDR_W-1:0] a);
        logic [31:0] byte_a;
        byte_a = {a, 3'h0};
        in_smm = (byte_a >= HBS_SMM_BASE) && (byte_a <= HBS_SMM_LIMIT);
    endfunction

    assign strobe     = !CPU_ADDR_STROBE_N_IN; // [R16] [R7]
    assign grant_hold = !SOUTHBRIDGE_HOLD_GRANT_N_IN;
    // snoop invalidate does not depend on this bit
    assign l1_unused  = L1_CACHE_ENABLE_BIT_IN; // [R13]

    // lock window opens on a strobe sampled with lock, closes on lock release
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            lock_q <= 1'b0;
        end else if (ATOMIC_LOCK_N_IN) begin
            lock_q <= 1'b0; // [R8]
        end else if (strobe) begin
            lock_q <= 1'b1; // [R8]
        end
    end

    // cpu cycle tracking, type decode and management access gate
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            cpu_busy_q <= 1'b0;
            cpu_read_q <= 1'b0;
            smm_ok_q   <= 1'b0;
        end else if (strobe && !ADDR_HOLD_OUT) begin
            cpu_busy_q <= 1'b1;
            cpu_read_q <= !WRITE_READ_IN && DATA_CTRL_IN; // [R7]
            // locked firmware space only opens in management mode
            smm_ok_q   <= !(MEM_IO_IN == HBS_MIO_MEM && in_smm(HOST_ADDR_IN))
                          || !SMM_LOCKED_IN || !MGMT_MODE_ACTIVE_N_IN; // [R14]
        end else if (cycle_backoff_n_q || (MEM_CPU_READY_IN && !MEM_CPU_NEXT_IN)) begin
            cpu_busy_q <= 1'b0;
        end
    end

    // arbitration between cpu cycles and pci initiators
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            st_q         <= HBS_IDLE;
            snoop_addr_strobe_n_q       <= 1'b0;
            cycle_backoff_n_q       <= 1'b0;
            dirty_q      <= 1'b0;
            snoop_addr_q <= '0;
        end else begin
            snoop_addr_strobe_n_q <= 1'b0;
            // abort is honoured on its own, or an open cpu cycle would hang waiting for ready
            cycle_backoff_n_q <= cpu_busy_q && MEM_CPU_ABORT_IN; // [R5]
            case (st_q)
                HBS_IDLE: begin
                    // no pci memory access inside a locked sequence
                    if (PCI_MEM_REQ_IN && !PCI_PEER_XFER_IN && !lock_q) begin // [R8] [R2]
                        st_q         <= HBS_HOLD; // [R1]
                        snoop_addr_q <= PCI_MEM_ADDR_IN;
                        dirty_q      <= 1'b0;
                    end
                end
                HBS_HOLD: begin
                    // address hold is up this cycle, so strobe is safe next
                    st_q   <= HBS_SNOOP;
                    snoop_addr_strobe_n_q <= 1'b1; // [R4] [R20]
                end
                HBS_SNOOP: begin
                    st_q <= HBS_HITWAIT;
                end
                HBS_HITWAIT: begin
                    // dirty hit: memory must wait for the writeback
                    dirty_q <= !SNOOP_DIRTY_HIT_N_IN; // [R6]
                    st_q    <= HBS_PCI_RUN;
                end
                HBS_PCI_RUN: begin
                    if (PCI_BURST_DONE_IN) begin
                        st_q <= HBS_IDLE; // [R2]
                    end
                end
                default: begin
                    st_q <= HBS_IDLE;
                end
            endcase
        end
    end

    // bus ready, next-address and data registers toward the processor
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rdy_q      <= 1'b0;
            na_q       <= 1'b0;
            rd_data_q  <= '0;
            wr_data_q  <= '0;
            wr_valid_q <= 1'b0;
        end else begin
            rdy_q      <= cpu_busy_q && MEM_CPU_READY_IN && smm_ok_q; // [R17]
            na_q       <= cpu_busy_q && MEM_CPU_NEXT_IN; // [R18]
            rd_data_q  <= smm_ok_q ? MEM_RD_DATA_IN : '0;
            wr_data_q  <= HOST_DATA_BUS_IN; // [R15]
            wr_valid_q <= cpu_busy_q && !cpu_read_q && MEM_CPU_READY_IN && smm_ok_q;
        end
    end

    hbs_ken_gen u_ken (
        .clk_in             (SYS_CLK_IN),
        .arst_n_in          (ARST_N_IN),
        .cpu_cycle_start_in (strobe && !ADDR_HOLD_OUT),
        .cpu_cacheable_in   (!CACHE_CYCLE_N_IN), // [R9]
        .cpu_read_in        (!WRITE_READ_IN),
        .cpu_first_ready_in (cpu_busy_q && MEM_CPU_READY_IN),
        .cpu_next_addr_in   (cpu_busy_q && MEM_CPU_NEXT_IN),
        .snoop_strobe_in    (st_q == HBS_HOLD),
        .snoop_write_in     (PCI_MEM_WRITE_IN),
        .cache_enable_invalidate_out        (CACHE_ENABLE_INVALIDATE_OUT)
    );

    assign ADDR_HOLD_OUT           = (st_q != HBS_IDLE) || grant_hold; // [R1] [R3]
    assign SNOOP_ADDR_STROBE_N_OUT = !snoop_addr_strobe_n_q;
    assign CYCLE_BACKOFF_N_OUT     = !cycle_backoff_n_q;
    assign BUS_READY_N_OUT         = !rdy_q;
    assign NEXT_ADDR_N_OUT         = !na_q;
    assign HOST_ADDR_OUT           = snoop_addr_q;
    assign HOST_ADDR_OE_OUT        = (st_q == HBS_SNOOP) || (st_q == HBS_HITWAIT); // [R19]
    assign HOST_DATA_BUS_OUT       = rd_data_q;
    assign HOST_DATA_BUS_OE_OUT    = rdy_q && cpu_read_q && !l1_unused ? 1'b1 : rdy_q && cpu_read_q;
    assign MEM_WR_DATA_OUT         = wr_data_q;
    assign MEM_WR_VALID_OUT        = wr_valid_q;
    assign PCI_MEM_GRANT_OUT       = (st_q == HBS_PCI_RUN) && !dirty_q;
    assign PCI_SNOOP_DIRTY_OUT     = (st_q == HBS_PCI_RUN) && dirty_q;
    assign SMM_ACCESS_OK_OUT       = smm_ok_q;
    assign CPU_CYCLE_LOCKED_OUT    = lock_q;
endmodule : hbs_bus_ctl // hbs_bus_ctl
`default_nettype wire

// File: dv/hbs_bus_ctl_checker.sv
// concurrent checks on the host bus snoop and cycle control ports
`timescale 1ns/100ps
`default_nettype none
module hbs_bus_ctl_checker
    import hbs_pkg::*;
(
    input wire logic                  SYS_CLK_IN, ARST_N_IN, ADDR_HOLD_OUT, SNOOP_ADDR_STROBE_N_OUT,
    input wire logic                  PCI_MEM_GRANT_OUT, PCI_SNOOP_DIRTY_OUT, SOUTHBRIDGE_HOLD_GRANT_N_IN,
    input wire logic                  CACHE_ENABLE_INVALIDATE_OUT, PCI_MEM_WRITE_IN, HOST_ADDR_OE_OUT,
    input wire logic                  PCI_BURST_DONE_IN, MEM_CPU_READY_IN, BUS_READY_N_OUT,
    input wire logic                  CYCLE_BACKOFF_N_OUT, MEM_CPU_ABORT_IN, CPU_CYCLE_LOCKED_OUT,
    input wire logic [HBS_ADDR_W-1:0] HOST_ADDR_OUT, PCI_MEM_ADDR_IN
);
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    chk_hold_over_burst: assert property ((PCI_MEM_GRANT_OUT || PCI_SNOOP_DIRTY_OUT) |-> ADDR_HOLD_OUT)
        else $error("address hold low during pci memory burst");
    chk_hold_after_done: assert property (PCI_BURST_DONE_IN ##1 SOUTHBRIDGE_HOLD_GRANT_N_IN |-> !ADDR_HOLD_OUT)
        else $error("address hold kept after burst end");
    chk_hold_sb_grant: assert property (!SOUTHBRIDGE_HOLD_GRANT_N_IN |-> ADDR_HOLD_OUT)
        else $error("address hold low while southbridge granted");
    chk_snoop_one_pulse: assert property ($fell(SNOOP_ADDR_STROBE_N_OUT) |=> SNOOP_ADDR_STROBE_N_OUT)
        else $error("snoop strobe longer than one cycle");
    chk_backoff_cause: assert property ($fell(CYCLE_BACKOFF_N_OUT) |-> $past(MEM_CPU_ABORT_IN) || $past(MEM_CPU_ABORT_IN, 2))
        else $error("back-off without abort request");
    chk_lock_no_grant: assert property (CPU_CYCLE_LOCKED_OUT |-> !$rose(PCI_MEM_GRANT_OUT))
        else $error("pci grant inside locked sequence");
    chk_snoop_inv_level: assert property (!SNOOP_ADDR_STROBE_N_OUT |-> CACHE_ENABLE_INVALIDATE_OUT == PCI_MEM_WRITE_IN)
        else $error("invalidate level wrong during snoop");
    chk_ready_follows: assert property (MEM_CPU_READY_IN |=> !BUS_READY_N_OUT)
        else $error("bus ready missing after memory ready");
    chk_snoop_addr_drive: assert property (!SNOOP_ADDR_STROBE_N_OUT |-> HOST_ADDR_OE_OUT && HOST_ADDR_OUT == PCI_MEM_ADDR_IN)
        else $error("snoop address not driven");
    chk_strobe_under_hold: assert property (!SNOOP_ADDR_STROBE_N_OUT |-> ADDR_HOLD_OUT && $past(ADDR_HOLD_OUT))
        else $error("snoop strobe without prior address hold");
    cov_dirty: cover property ($rose(PCI_SNOOP_DIRTY_OUT));
    cov_grant: cover property ($rose(PCI_MEM_GRANT_OUT));
    cov_backoff: cover property ($fell(CYCLE_BACKOFF_N_OUT));
endmodule // hbs_bus_ctl_checker
bind hbs_bus_ctl hbs_bus_ctl_checker u_chk (.*);
`default_nettype wire

// File: dv/hbs_cpu_model.sv
// behavioural processor on the host bus: cycle starts and snoop answers
`timescale 1ns/100ps
`default_nettype none
module hbs_cpu_model
    import hbs_pkg::*;
(
    input wire logic                  clk_in, go_in, wr_in, cache_n_in, dirty_in, snoop_n_in,
    input wire logic [HBS_ADDR_W-1:0] addr_in,
    output logic                      strobe_n_out = 1'b1, mio_out = 1'b0, dc_out = 1'b0, wr_out = 1'b0,
    output logic                      cache_n_out = 1'b1, snoop_dirty_hit_n_n_out = 1'b1,
    output logic      [HBS_ADDR_W-1:0] addr_out = '0
);
    logic [2:0] seen_q = 3'h0;
    // off-cycle values flip so a stale sample never looks valid
    always @(posedge clk_in) begin
        strobe_n_out <= !go_in;
        mio_out      <= go_in ? HBS_MIO_MEM : !mio_out;
        dc_out       <= go_in ? 1'b1 : !dc_out;
        wr_out       <= go_in ? wr_in : !wr_out;
        cache_n_out  <= go_in ? cache_n_in : !cache_n_out;
        addr_out     <= go_in ? addr_in : ~addr_out;
    end
    // dirty hit answered for four cycles after the snoop strobe
    always @(posedge clk_in) begin
        seen_q     <= {seen_q[1:0], !snoop_n_in};
        snoop_dirty_hit_n_n_out <= !(dirty_in && (seen_q != 3'h0 || !snoop_n_in));
    end
endmodule // hbs_cpu_model
`default_nettype wire

// File: dv/hbs_bus_ctl_test.sv
// self-checking bench for the host bus snoop and cycle control block
`timescale 1ns/100ps
`default_nettype none
module hbs_bus_ctl_test;
    import hbs_pkg::*;
    typedef struct packed {logic ken; logic rd; logic [HBS_DATA_W-1:0] d;} hbs_note_s;
    logic SYS_CLK_IN = 0, ARST_N_IN = 0, ATOMIC_LOCK_N_IN = 1, MGMT_MODE_ACTIVE_N_IN = 1, MEM_CPU_READY_IN = 0;
    logic MEM_CPU_NEXT_IN = 0, MEM_CPU_ABORT_IN = 0, PCI_MEM_REQ_IN = 0, PCI_MEM_WRITE_IN = 0, PCI_BURST_DONE_IN = 0;
    logic PCI_PEER_XFER_IN = 0, SOUTHBRIDGE_HOLD_GRANT_N_IN = 1, L1_CACHE_ENABLE_BIT_IN = 0, SMM_LOCKED_IN = 1;
    logic CPU_ADDR_STROBE_N_IN, MEM_IO_IN, DATA_CTRL_IN, WRITE_READ_IN, CACHE_CYCLE_N_IN, SNOOP_DIRTY_HIT_N_IN;
    logic HOST_ADDR_OE_OUT, HOST_DATA_BUS_OE_OUT, ADDR_HOLD_OUT, SNOOP_ADDR_STROBE_N_OUT, CYCLE_BACKOFF_N_OUT;
    logic CACHE_ENABLE_INVALIDATE_OUT, BUS_READY_N_OUT, NEXT_ADDR_N_OUT, MEM_WR_VALID_OUT, PCI_MEM_GRANT_OUT;
    logic PCI_SNOOP_DIRTY_OUT, SMM_ACCESS_OK_OUT, CPU_CYCLE_LOCKED_OUT, go = 0, mwr = 0, mcn = 1, dirty = 0, pd;
    logic prev_pd = 0, seen;
    logic [HBS_ADDR_W-1:0] HOST_ADDR_IN, HOST_ADDR_OUT, PCI_MEM_ADDR_IN = '0, maddr = '0;
    logic [HBS_DATA_W-1:0] HOST_DATA_BUS_IN = '0, HOST_DATA_BUS_OUT, MEM_RD_DATA_IN = '0, MEM_WR_DATA_OUT;
    int err_count = 0, num_checks = 0;
    hbs_note_s rdy_q[$], n;
    logic pci_q[$], na_q[$];
    hbs_bus_ctl uut (.*);
    hbs_cpu_model u_cpu (.clk_in(SYS_CLK_IN), .go_in(go), .wr_in(mwr), .cache_n_in(mcn), .dirty_in(dirty),
        .snoop_n_in(SNOOP_ADDR_STROBE_N_OUT), .addr_in(maddr), .strobe_n_out(CPU_ADDR_STROBE_N_IN),
        .mio_out(MEM_IO_IN), .dc_out(DATA_CTRL_IN), .wr_out(WRITE_READ_IN), .cache_n_out(CACHE_CYCLE_N_IN),
        .snoop_dirty_hit_n_n_out(SNOOP_DIRTY_HIT_N_IN), .addr_out(HOST_ADDR_IN));
    always #12.5 SYS_CLK_IN = ~SYS_CLK_IN;
    task automatic chk(input logic ok);
        num_checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[ERR] %0t result mismatch", $time);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge SYS_CLK_IN);
        #1;
    endtask
    task automatic give_verdict();
        if (err_count == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic pci(input logic wr, input logic dh);
        int i;
        PCI_MEM_ADDR_IN = HBS_ADDR_W'($urandom);
        PCI_MEM_WRITE_IN = wr;
        L1_CACHE_ENABLE_BIT_IN = 1'($urandom);
        dirty = dh;
        pci_q.push_back(dh);
        PCI_MEM_REQ_IN = 1;
        for (i = 0; i < 40 && pd !== 1'b1; i++) step(1);
        step(2);
        chk(ADDR_HOLD_OUT === 1'b1);
        PCI_BURST_DONE_IN = 1;
        PCI_MEM_REQ_IN = 0;
        step(1);
        PCI_BURST_DONE_IN = 0;
        step(1);
        chk(ADDR_HOLD_OUT === 1'b0);
        dirty = 0;
        step(2);
    endtask
    // mode 0 completes with ready, 1 leaves the cycle open, 2 aborts it, 3 gives next-address before ready
    task automatic cpu(input logic wr, input logic cn, input logic [HBS_ADDR_W-1:0] a, input int mode);
        mwr = wr;
        mcn = cn;
        maddr = a;
        MEM_RD_DATA_IN = {$urandom, $urandom};
        HOST_DATA_BUS_IN = {$urandom, $urandom};
        go = 1;
        step(1);
        go = 0;
        step(1);
        // once next-address has carried the cache decision, the line is low again at ready
        if (mode == 0 || mode == 3)
            rdy_q.push_back('{ken: mode == 0 && !wr && cn, rd: !wr, d: wr ? HOST_DATA_BUS_IN : MEM_RD_DATA_IN});
        if (mode == 3) na_q.push_back(!wr && cn);
        MEM_CPU_READY_IN = (mode == 0);
        MEM_CPU_NEXT_IN = (mode == 3);
        MEM_CPU_ABORT_IN = (mode == 2);
        step(1);
        MEM_CPU_READY_IN = (mode == 3);
        MEM_CPU_NEXT_IN = 0;
        MEM_CPU_ABORT_IN = 0;
        seen = 0;
        repeat (3) begin
            if (CYCLE_BACKOFF_N_OUT === 1'b0) seen = 1;
            step(1);
            MEM_CPU_READY_IN = 0;
        end
        if (mode == 2) chk(seen === 1'b1);
    endtask
    always @(posedge SYS_CLK_IN) begin
        pd = PCI_MEM_GRANT_OUT | PCI_SNOOP_DIRTY_OUT;
        if (pd === 1'b1 && prev_pd !== 1'b1) begin
            if (pci_q.size() == 0) chk(1'b0);
            else chk(PCI_SNOOP_DIRTY_OUT === pci_q.pop_front());
        end
        prev_pd = pd;
        if (NEXT_ADDR_N_OUT === 1'b0) begin
            if (na_q.size() == 0) chk(1'b0);
            else chk(CACHE_ENABLE_INVALIDATE_OUT === na_q.pop_front());
        end
        if (BUS_READY_N_OUT === 1'b0) begin
            if (rdy_q.size() == 0) chk(1'b0);
            else begin
                n = rdy_q.pop_front();
                chk(CACHE_ENABLE_INVALIDATE_OUT === n.ken);
                if (n.rd) chk(HOST_DATA_BUS_OUT === n.d && HOST_DATA_BUS_OE_OUT === 1'b1);
                else chk(MEM_WR_VALID_OUT === 1'b1 && MEM_WR_DATA_OUT === n.d);
            end
        end
    end
    initial begin
        #(25 * 4000);
        err_count++;
        give_verdict();
    end
    initial begin
        void'($urandom(73198));
        repeat (16) @(posedge SYS_CLK_IN);
        #1 ARST_N_IN = 1;
        step(1);
        for (int i = 0; i < 4; i++) pci(i[0], i[1]);
        for (int i = 0; i < 4; i++) cpu(i == 2, i[0], {1'b1, 28'($urandom)}, i == 3 ? 3 : 0);
        cpu(0, 1, {1'b1, 28'($urandom)}, 2);
        cpu(0, 1, HBS_SMM_BASE[31:3], 1);
        chk(SMM_ACCESS_OK_OUT === 1'b0);
        MGMT_MODE_ACTIVE_N_IN = 0;
        cpu(0, 1, HBS_SMM_BASE[31:3], 1);
        chk(SMM_ACCESS_OK_OUT === 1'b1);
        MGMT_MODE_ACTIVE_N_IN = 1;
        PCI_PEER_XFER_IN = 1;
        PCI_MEM_REQ_IN = 1;
        step(4);
        chk(ADDR_HOLD_OUT === 1'b0);
        PCI_MEM_REQ_IN = 0;
        PCI_PEER_XFER_IN = 0;
        SOUTHBRIDGE_HOLD_GRANT_N_IN = 0;
        step(3);
        chk(ADDR_HOLD_OUT === 1'b1);
        SOUTHBRIDGE_HOLD_GRANT_N_IN = 1;
        step(2);
        ATOMIC_LOCK_N_IN = 0;
        cpu(0, 0, {1'b1, 28'($urandom)}, 0);
        fork
            begin
                step(12);
                // request has waited the whole locked stretch without a snoop starting
                chk(ADDR_HOLD_OUT === 1'b0);
                ATOMIC_LOCK_N_IN = 1;
            end
        join_none
        pci(0, 0);
        step(4);
        chk(pci_q.size() == 0 && rdy_q.size() == 0 && na_q.size() == 0);
        give_verdict();
    end
endmodule // hbs_bus_ctl_test
`default_nettype wire
